/* hdl/mra_ctrl.sv */
// Controller end: issues commands on the link and spaces them by counters.
// Assumes the DRAM end answers a register read after read latency.
`timescale 1ns/1ps
`default_nettype none
module mra_ctrl
	import mra_pkg::*;
#(
	parameter int RL        = DEF_RL,
	parameter int WL        = DEF_WL,
	parameter int BL        = DEF_BL,
	parameter int READ_TO_PRECHARGE_CYCLES      = DEF_READ_TO_PRECHARGE_CYCLES,
	parameter int WRITE_RECOVERY_CYCLES       = DEF_NWR,
	parameter int RPST_X2   = DEF_RPST_X2,
	parameter int WRITE_TO_READ_TURNAROUND_PS   = DEF_WRITE_TO_READ_TURNAROUND_PS,
	parameter int STROBE_OUTPUT_DELAY_PS = DEF_STROBE_OUTPUT_DELAY_PS,
	parameter int TXP_PS    = DEF_TXP_PS,
	parameter int ACTIVATE_TO_COLUMN_DELAY_PS   = DEF_ACTIVATE_TO_COLUMN_DELAY_PS,
	parameter int REG_READ_BUSY_TIME_CK   = DEF_REG_READ_BUSY_TIME_CK,
	parameter int REG_WRITE_PERIOD_PS   = DEF_REG_WRITE_PERIOD_PS,
	parameter int REG_SET_DELAY_PS   = DEF_REG_SET_DELAY_PS
)
(
	input  wire logic             ref_clk,   // 100 MHz clock
	input  wire logic             srst,      // Sync reset, high
	mra_link_if.ctrl              link,      // Link to DRAM
	input  wire logic             req_valid, // Command request
	input  wire mra_cmd_t         req_cmd,   // Requested command
	input  wire logic [MR_AW-1:0] req_addr,  // Register address
	input  wire logic [MR_DW-1:0] req_data,  // Register write data
	output logic                  mrr_ready, // Register read may issue
	output logic                  mrw_ready, // Register write may issue
	output logic                  cmd_ready, // Other commands may issue
	output logic                  rd_valid,  // Pulse, rd_data valid
	output logic      [MR_DW-1:0] rd_data,   // Register read value
	output logic                  pwr_down   // Link in power-down
);

	// ----------------------------------------------------------------
	// Spacing counts, loaded as cycles minus one
	// ----------------------------------------------------------------
	localparam int TURN_CK = (ru_ck(TURN_MIN_PS) > TURN_MIN_CK) ? ru_ck(TURN_MIN_PS) : TURN_MIN_CK;
	localparam int RD_MRW  = RL + BL / 2 + ru_ck(STROBE_OUTPUT_DELAY_PS) + RPST_X2 / 2 + TURN_CK;
	localparam int WR_MRW  = WL + WR_EXTRA_CK + BL / 2 + TURN_CK;
	localparam int REG_WRITE_PERIOD_CK = ru_ck(REG_WRITE_PERIOD_PS);
	localparam int REG_SET_DELAY_CK = ru_ck(REG_SET_DELAY_PS);

	localparam logic [CNT_W-1:0] D_RD_MRR   = CNT_W'(BL / 2 - 1);
	localparam logic [CNT_W-1:0] D_WR_MRR   = CNT_W'(WL + BL / 2 + WR_EXTRA_CK + ru_ck(WRITE_TO_READ_TURNAROUND_PS) - 1);
	localparam logic [CNT_W-1:0] D_RD_MRW   = CNT_W'(RD_MRW - 1);
	localparam logic [CNT_W-1:0] D_RDA_MRW  = CNT_W'(RD_MRW + READ_TO_PRECHARGE_CYCLES - RTP_BIAS - 1);
	localparam logic [CNT_W-1:0] D_WR_MRW   = CNT_W'(WR_MRW - 1);
	localparam logic [CNT_W-1:0] D_WRA_MRW  = CNT_W'(WR_MRW + WRITE_RECOVERY_CYCLES - 1);
	localparam logic [CNT_W-1:0] D_MRR_BUSY = CNT_W'(REG_READ_BUSY_TIME_CK - 1);
	localparam logic [CNT_W-1:0] D_MRR_MRW  = CNT_W'(RL + ru_ck(STROBE_OUTPUT_DELAY_PS) + BL / 2 + MRR_MRW_EXTRA - 1);
	localparam logic [CNT_W-1:0] D_MRW_MRW  = CNT_W'(REG_WRITE_PERIOD_CK - 1);
	localparam logic [CNT_W-1:0] D_MRW_BUSY = CNT_W'(REG_WRITE_PERIOD_CK + REG_SET_DELAY_CK - 1);
	localparam logic [CNT_W-1:0] D_PDX_MRR  = CNT_W'(ru_ck(TXP_PS) + ru_ck(ACTIVATE_TO_COLUMN_DELAY_PS) - 1);
	localparam logic [CNT_W-1:0] D_PDX_ANY  = CNT_W'(ru_ck(TXP_PS) - 1);
	localparam logic [1:0]       MRR_WORDS  = 2'd1;
	localparam logic [1:0]       MRW_WORDS  = 2'd3;

	logic [CNT_W-1:0] g_mrr_ff;
	logic [CNT_W-1:0] g_mrw_ff;
	logic [CNT_W-1:0] g_any_ff;
	logic [CNT_W-1:0] nxt_g_mrr;
	logic [CNT_W-1:0] nxt_g_mrw;
	logic [CNT_W-1:0] nxt_g_any;
	logic [CNT_W-1:0] d_mrr;
	logic [CNT_W-1:0] d_mrw;
	logic [CNT_W-1:0] d_any;
	logic [1:0]       words_ff;
	logic [1:0]       nxt_words;
	logic [CA_W-1:0]  q_ff [3];
	logic [CA_W-1:0]  op;
	logic             ready_sel;
	logic             accept;
	logic             mrr_rdy_ff;
	logic             mrw_rdy_ff;
	logic             cmd_rdy_ff;
	logic             cke_ff;
	logic             cs_ff;
	logic [CA_W-1:0]  ca_ff;
	logic             oe_n_q_ff;
	logic             rdv_ff;
	logic [MR_DW-1:0] rdd_ff;

	// ----------------------------------------------------------------
	// Request acceptance
	// ----------------------------------------------------------------
	always_comb
	begin
		case (req_cmd)
			CMD_MRR: ready_sel = mrr_rdy_ff;
			CMD_MRW: ready_sel = mrw_rdy_ff;
			default: ready_sel = cmd_rdy_ff;
		endcase
	end

	// In power-down only the exit is taken
	assign accept = req_valid && ready_sel && (cke_ff ? (req_cmd != CMD_PDX) : (req_cmd == CMD_PDX));

	// ----------------------------------------------------------------
	// Delay selection per issued command
	// ----------------------------------------------------------------
	always_comb
	begin
		d_mrr = '0;
		d_mrw = '0;
		d_any = '0;
		op    = OP_NONE;
		case (req_cmd)
			CMD_ACT: op = OP_ACT;
			CMD_PRE: op = OP_PRE;
			CMD_RD:
			begin
				op    = OP_RD;
				d_mrr = D_RD_MRR;
				d_mrw = D_RD_MRW;
			end
			CMD_RDA:
			begin
				op    = OP_RDA;
				d_mrr = D_RD_MRR;
				d_mrw = D_RDA_MRW;
			end
			CMD_WR, CMD_MWR, CMD_WFIFO:
			begin
				op    = (req_cmd == CMD_WR) ? OP_WR : ((req_cmd == CMD_MWR) ? OP_MWR : OP_WFIFO);
				d_mrr = D_WR_MRR;
				d_mrw = D_WR_MRW;
			end
			CMD_WRA, CMD_MWRA:
			begin
				op    = (req_cmd == CMD_WRA) ? OP_WRA : OP_MWRA;
				d_mrr = D_WR_MRR;
				d_mrw = D_WRA_MRW;
			end
			CMD_MRR:
			begin
				op    = OP_MRR;
				d_any = D_MRR_BUSY;
				d_mrw = D_MRR_MRW;
			end
			CMD_MRW:
			begin
				op    = OP_MRW;
				d_mrw = D_MRW_MRW;
				d_any = D_MRW_BUSY;
			end
			CMD_PDX:
			begin
				d_mrr = D_PDX_MRR;
				d_any = D_PDX_ANY;
			end
			default: op = OP_NONE;
		endcase
	end

	// ----------------------------------------------------------------
	// Spacing counters
	// ----------------------------------------------------------------
	function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] cur, input logic ld,
		input logic [CNT_W-1:0] d);
		logic [CNT_W-1:0] dec;
		dec = (cur == '0) ? cur : cur - CNT_W'(1);
		return (ld && d > dec) ? d : dec;
	endfunction

	always_comb
	begin
		nxt_g_mrr = step(g_mrr_ff, accept, d_mrr);
		nxt_g_mrw = step(g_mrw_ff, accept, d_mrw);
		nxt_g_any = step(g_any_ff, accept, d_any);
		if (accept && req_cmd == CMD_MRR)
			nxt_words = MRR_WORDS;
		else if (accept && req_cmd == CMD_MRW)
			nxt_words = MRW_WORDS;
		else
			nxt_words = (words_ff == 2'd0) ? 2'd0 : words_ff - 2'd1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			g_mrr_ff <= '0;
			g_mrw_ff <= '0;
			g_any_ff <= '0;
			words_ff <= 2'd0;
		end
		else
		begin
			g_mrr_ff <= nxt_g_mrr;
			g_mrw_ff <= nxt_g_mrw;
			g_any_ff <= nxt_g_any;
			words_ff <= nxt_words;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			mrr_rdy_ff <= 1'b0;
			mrw_rdy_ff <= 1'b0;
			cmd_rdy_ff <= 1'b0;
		end
		else
		begin
			cmd_rdy_ff <= (nxt_g_any == '0) && (nxt_words == 2'd0);
			mrr_rdy_ff <= (nxt_g_any == '0) && (nxt_words == 2'd0) && (nxt_g_mrr == '0);
			mrw_rdy_ff <= (nxt_g_any == '0) && (nxt_words == 2'd0) && (nxt_g_mrw == '0);
		end
	end

	// ----------------------------------------------------------------
	// Link words: opcode; MRR adds the address, MRW adds address, data low and high
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			cs_ff   <= 1'b0;
			ca_ff   <= OP_NONE;
			q_ff[0] <= OP_NONE;
			q_ff[1] <= OP_NONE;
			q_ff[2] <= OP_NONE;
		end
		else if (accept && req_cmd != CMD_PDE && req_cmd != CMD_PDX)
		begin
			cs_ff   <= 1'b1;
			ca_ff   <= op;
			q_ff[0] <= req_addr;
			q_ff[1] <= req_data[5:0];
			q_ff[2] <= {4'h0, req_data[7:6]};
		end
		else if (words_ff != 2'd0)
		begin
			cs_ff   <= 1'b1;
			ca_ff   <= q_ff[0];
			q_ff[0] <= q_ff[1];
			q_ff[1] <= q_ff[2];
			q_ff[2] <= OP_NONE;
		end
		else
		begin
			cs_ff <= 1'b0;
			ca_ff <= OP_NONE;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			cke_ff <= 1'b1;
		else if (accept && req_cmd == CMD_PDE)
			cke_ff <= 1'b0;
		else if (accept && req_cmd == CMD_PDX)
			cke_ff <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Read capture on the first driven beat
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			oe_n_q_ff <= 1'b1;
			rdv_ff    <= 1'b0;
			rdd_ff    <= MR_RST_VAL;
		end
		else
		begin
			oe_n_q_ff <= link.dq_oe_n;
			rdv_ff    <= oe_n_q_ff && !link.dq_oe_n;
			if (oe_n_q_ff && !link.dq_oe_n)
				rdd_ff <= link.dq;
		end
	end

	assign link.cke = cke_ff;
	assign link.cs  = cs_ff;
	assign link.ca  = ca_ff;
	assign mrr_ready = mrr_rdy_ff;
	assign mrw_ready = mrw_rdy_ff;
	assign cmd_ready = cmd_rdy_ff;
	assign rd_valid  = rdv_ff;
	assign rd_data   = rdd_ff;
	assign pwr_down  = !cke_ff;

endmodule
`default_nettype wire

/* hdl/mra_pkg.sv */
// Shared constants, command codes and timing defaults for the mode register
// access link. Assumes a single 100 MHz clock shared by both ends.
`default_nettype none
package mra_pkg;

	// ----------------------------------------------------------------
	// Link geometry
	// ----------------------------------------------------------------
	localparam int CA_W            = 6;
	localparam int MR_AW           = 6;
	localparam int MR_DW           = 8;
	localparam int MR_COUNT        = 64;
	localparam int MRR_BEATS       = 16;
	localparam int MRR_VALID_BEATS = 4;
	localparam int CNT_W           = 8;
	localparam logic [MR_DW-1:0] MR_RST_VAL = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int TCK_PS        = 10000;
	localparam int TURN_MIN_PS   = 7500;
	localparam int TURN_MIN_CK   = 8;
	localparam int RTP_BIAS      = 8;
	localparam int WR_EXTRA_CK   = 1;
	localparam int MRR_MRW_EXTRA = 3;
	localparam int DEF_RL        = 14;
	localparam int DEF_WL        = 8;
	localparam int DEF_BL        = 16;
	localparam int DEF_READ_TO_PRECHARGE_CYCLES      = 8;
	localparam int DEF_NWR       = 6;
	localparam int DEF_RPST_X2   = 1;
	localparam int DEF_WRITE_TO_READ_TURNAROUND_PS   = 10000;
	localparam int DEF_STROBE_OUTPUT_DELAY_PS = 3500;
	localparam int DEF_TXP_PS    = 7500;
	localparam int DEF_ACTIVATE_TO_COLUMN_DELAY_PS   = 18000;
	localparam int DEF_REG_READ_BUSY_TIME_CK   = 8;
	localparam int DEF_REG_WRITE_PERIOD_PS   = 10000;
	localparam int DEF_REG_SET_DELAY_PS   = 14000;

	// Round up a time to whole cycles, never below one
	function automatic int ru_ck(input int ps);
		int c;
		c = (ps + TCK_PS - 1) / TCK_PS;
		return (c < 1) ? 1 : c;
	endfunction

	// ----------------------------------------------------------------
	// Command opcodes on the first word
	// ----------------------------------------------------------------
	localparam logic [CA_W-1:0] OP_NONE  = 6'h00;
	localparam logic [CA_W-1:0] OP_ACT   = 6'h01;
	localparam logic [CA_W-1:0] OP_PRE   = 6'h02;
	localparam logic [CA_W-1:0] OP_RD    = 6'h04;
	localparam logic [CA_W-1:0] OP_RDA   = 6'h05;
	localparam logic [CA_W-1:0] OP_WR    = 6'h08;
	localparam logic [CA_W-1:0] OP_WRA   = 6'h09;
	localparam logic [CA_W-1:0] OP_MWR   = 6'h0A;
	localparam logic [CA_W-1:0] OP_MWRA  = 6'h0B;
	localparam logic [CA_W-1:0] OP_WFIFO = 6'h0C;
	localparam logic [CA_W-1:0] OP_MRR   = 6'h0E;
	localparam logic [CA_W-1:0] OP_MRW   = 6'h0F;

	typedef enum logic [3:0] {
		CMD_ACT, CMD_PRE, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_MWR,
		CMD_MWRA, CMD_WFIFO, CMD_MRR, CMD_MRW, CMD_PDE, CMD_PDX
	} mra_cmd_t;

endpackage
`default_nettype wire

/* hdl/mra_link_if.sv */
// Command/address and read data link between controller and DRAM.
// Assumes both ends run on the same ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface mra_link_if;
	logic       cke;     // Clock enable, low in power-down
	logic       cs;      // Word valid
	logic [5:0] ca;      // Command/address word
	logic [7:0] dq;      // Read data from DRAM
	logic       dq_oe_n; // Low while DRAM drives dq

	modport ctrl (output cke, output cs, output ca, input dq, input dq_oe_n);
	modport dram (input cke, input cs, input ca, output dq, output dq_oe_n);
endinterface
`default_nettype wire

/* hdl/mra_dram.sv */
// DRAM end: decodes commands, holds 64 mode registers, answers reads.
// Assumes the controller keeps all command spacing on the link.
`timescale 1ns/1ps
`default_nettype none
module mra_dram
	import mra_pkg::*;
#(
	parameter int          RL      = DEF_RL,
	parameter logic [63:0] RO_MASK = 64'h0000_0000_0000_0101
)
(
	input  wire logic             ref_clk,     // 100 MHz clock
	input  wire logic             srst,        // Sync reset, high
	mra_link_if.dram              link,        // Link to controller
	input  wire logic [MR_AW-1:0] peek_addr,   // Local register peek address
	output logic      [MR_DW-1:0] peek_data,   // Peeked register value
	output logic                  bank_active, // Some bank open
	output logic                  pwr_down,    // In power-down
	output logic                  mrw_seen     // Pulse per accepted MODE_REG_WRITE_CMD
);

	typedef enum logic [2:0] {ST_CMD, ST_MRR_ADDR, ST_MRW_ADDR, ST_MRW_LO, ST_MRW_HI} mra_dst_t;

	localparam logic [CNT_W-1:0] RD_SPAN  = CNT_W'(RL + MRR_BEATS);
	localparam logic [CNT_W-1:0] BEATS_CK = CNT_W'(MRR_BEATS);
	localparam logic [CNT_W-1:0] VALID_LO = CNT_W'(MRR_BEATS - MRR_VALID_BEATS);

	mra_dst_t         st_ff;
	logic [MR_DW-1:0] mr_ff [MR_COUNT];
	logic [MR_AW-1:0] wa_ff;
	logic [MR_AW-1:0] ra_ff;
	logic [5:0]       wlo_ff;
	logic             wr_en;
	logic [CNT_W-1:0] dly_ff;
	logic             take;
	logic [7:0]       dq_ff;
	logic             oe_n_ff;
	logic             bank_ff;
	logic             pd_ff;
	logic             seen_ff;
	logic [MR_DW-1:0] peek_ff;

	assign take = link.cke && link.cs;
	assign wr_en = take && (st_ff == ST_MRW_HI);

	// ----------------------------------------------------------------
	// Word decoder
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			st_ff <= ST_CMD;
		else if (take)
		begin
			case (st_ff)
				ST_CMD:
				begin
					if (link.ca == OP_MRR)
						st_ff <= ST_MRR_ADDR;
					else if (link.ca == OP_MRW)
						st_ff <= ST_MRW_ADDR;
				end
				ST_MRR_ADDR: st_ff <= ST_CMD;
				ST_MRW_ADDR: st_ff <= ST_MRW_LO;
				ST_MRW_LO:   st_ff <= ST_MRW_HI;
				ST_MRW_HI:   st_ff <= ST_CMD;
				default:     st_ff <= ST_CMD;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			wa_ff  <= '0;
			wlo_ff <= '0;
		end
		else if (take && st_ff == ST_MRW_ADDR)
			wa_ff <= link.ca;
		else if (take && st_ff == ST_MRW_LO)
			wlo_ff <= link.ca;
	end

	// ----------------------------------------------------------------
	// Mode registers
	// ----------------------------------------------------------------
	for (genvar i = 0; i < MR_COUNT; i++)
	begin : g_mr
		always_ff @(posedge ref_clk)
		begin
			if (srst)
				mr_ff[i] <= MR_RST_VAL;
			else if (wr_en && wa_ff == MR_AW'(i) && !RO_MASK[i])
				mr_ff[i] <= {link.ca[1:0], wlo_ff};
		end
	end

	// ----------------------------------------------------------------
	// Read answer: value on the first beats, then zero
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			ra_ff  <= '0;
			dly_ff <= '0;
		end
		else if (take && st_ff == ST_MRR_ADDR)
		begin
			ra_ff  <= link.ca;
			dly_ff <= RD_SPAN;
		end
		else if (dly_ff != '0)
			dly_ff <= dly_ff - CNT_W'(1);
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			dq_ff   <= 8'h00;
			oe_n_ff <= 1'b1;
		end
		else if (dly_ff != '0 && dly_ff <= BEATS_CK)
		begin
			oe_n_ff <= 1'b0;
			dq_ff   <= (dly_ff > VALID_LO) ? mr_ff[ra_ff] : 8'h00;
		end
		else
		begin
			oe_n_ff <= 1'b1;
			dq_ff   <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Bank and power state
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			bank_ff <= 1'b0;
		else if (take && st_ff == ST_CMD)
		begin
			// MODE_REG_READ_CMD and MODE_REG_WRITE_CMD leave the bank state as it was
			case (link.ca)
				OP_ACT:                           bank_ff <= 1'b1;
				OP_PRE, OP_RDA, OP_WRA, OP_MWRA:  bank_ff <= 1'b0;
				default:                          bank_ff <= bank_ff;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			pd_ff   <= 1'b0;
			seen_ff <= 1'b0;
			peek_ff <= MR_RST_VAL;
		end
		else
		begin
			pd_ff   <= !link.cke;
			seen_ff <= wr_en;
			peek_ff <= mr_ff[peek_addr];
		end
	end

	assign link.dq      = dq_ff;
	assign link.dq_oe_n = oe_n_ff;
	assign peek_data    = peek_ff;
	assign bank_active  = bank_ff;
	assign pwr_down     = pd_ff;
	assign mrw_seen     = seen_ff;

endmodule
`default_nettype wire

/* sim/mra_link_properties.sv */
// Link checker: command spacing and read burst shape between both ends.
// Assumes it watches the shared link interface on ref_clk, srst high.
`timescale 1ns/1ps
`default_nettype none
module mra_link_properties
	import mra_pkg::*;
(
	input wire logic       ref_clk, // 100 MHz clock
	input wire logic       srst,    // Sync reset, high
	input wire logic       cke,     // Clock enable
	input wire logic       cs,      // Word valid
	input wire logic [5:0] ca,      // Command/address word
	input wire logic [7:0] dq,      // Read data
	input wire logic       dq_oe_n  // Low while DRAM drives dq
);
	// ----------------------------------------------------------------
	// Word tracking
	// ----------------------------------------------------------------
	logic [1:0] skip_ff;
	logic [7:0] rd_age_ff;
	logic [7:0] wr_age_ff;
	logic [7:0] mrr_age_ff;
	logic       first_w;
	logic       rd_op;
	logic       wr_op;
	logic       mrr_op;
	logic       mrw_op;

	assign first_w = cke && cs && (skip_ff == 2'h0);
	assign rd_op   = first_w && (ca == OP_RD || ca == OP_RDA);
	assign wr_op   = first_w && (ca == OP_WR || ca == OP_WRA || ca == OP_MWR || ca == OP_MWRA || ca == OP_WFIFO);
	assign mrr_op  = first_w && (ca == OP_MRR);
	assign mrw_op  = first_w && (ca == OP_MRW);

	function automatic logic [7:0] age_nxt(input logic op, input logic [7:0] age);
		return op ? 8'h00 : ((age == 8'hFF) ? age : age + 8'h01);
	endfunction

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			skip_ff <= 2'h0;
		else if (mrr_op)
			skip_ff <= 2'h1;
		else if (mrw_op)
			skip_ff <= 2'h3;
		else if (cs && skip_ff != 2'h0)
			skip_ff <= skip_ff - 2'h1;
	end

	always_ff @(posedge ref_clk)
	begin
		rd_age_ff  <= srst ? 8'hFF : age_nxt(rd_op, rd_age_ff);
		wr_age_ff  <= srst ? 8'hFF : age_nxt(wr_op, wr_age_ff);
		mrr_age_ff <= srst ? 8'hFF : age_nxt(mrr_op, mrr_age_ff);
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_mrw_word_train: assert property (mrw_op |=> cs ##1 cs ##1 (cs && ca[5:2] == 4'h0))
		else $error("register write words broken");
	a_mrr_busy_quiet: assert property (mrr_op |=> cs ##1 !cs [*6])
		else $error("command during register read busy");
	a_read_to_mrr: assert property (mrr_op |-> rd_age_ff >= 8'h07)
		else $error("register read too soon after read");
	a_write_to_mrr: assert property (mrr_op |-> wr_age_ff >= 8'h11)
		else $error("register read too soon after write");
	a_wake_to_mrr: assert property ($rose(cke) |-> !mrr_op [*3])
		else $error("register read too soon after wake");
	a_read_to_mrw: assert property (mrw_op |-> rd_age_ff >= 8'h1E)
		else $error("register write too soon after read");
	a_write_to_mrw: assert property (mrw_op |-> wr_age_ff >= 8'h18)
		else $error("register write too soon after write");
	a_mrr_to_mrw: assert property (mrw_op |-> mrr_age_ff >= 8'h19)
		else $error("register write too soon after register read");
	a_dq_idle_zero: assert property (dq_oe_n |-> dq == 8'h00)
		else $error("dq not zero while released");
	a_burst_sixteen: assert property ($fell(dq_oe_n) |-> !dq_oe_n [*8] ##1 !dq_oe_n [*8] ##1 dq_oe_n)
		else $error("read burst not sixteen beats");

	c_mrw: cover property (mrw_op);
	c_mrr: cover property (mrr_op);
	c_wake: cover property ($rose(cke));
	c_burst: cover property ($fell(dq_oe_n));
endmodule
`default_nettype wire

/* sim/mode_register_access_timing_tb_top.sv */
// Testbench: controller and DRAM ends joined by the link interface.
// Assumes package defaults for timing; registers 0 and 8 read-only.
`timescale 1ns/1ps
`default_nettype none
module mode_register_access_timing_tb_top;
	import mra_pkg::*;
	localparam logic [63:0] RO_MASK_TB = 64'h0000_0000_0000_0101;

	logic             ref_clk;
	logic             srst;
	logic             req_valid;
	mra_cmd_t         req_cmd;
	logic [MR_AW-1:0] req_addr;
	logic [MR_DW-1:0] req_data;
	logic [MR_AW-1:0] peek_addr;
	logic             mrr_ready;
	logic             mrw_ready;
	logic             cmd_ready;
	logic             rd_valid;
	logic [MR_DW-1:0] rd_data;
	logic             pwr_down;
	logic [MR_DW-1:0] peek_data;
	logic             bank_active;
	logic             dram_pd;
	logic             mrw_seen;
	logic [MR_DW-1:0] exp_mr [MR_COUNT];
	int               errors;
	int               checked;
	int               cyc;
	int               mrw_cnt;
	int               seen_cnt;
	int               seed;
	mra_cmd_t         src [7] = '{CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_MWR, CMD_MWRA, CMD_WFIFO};
	logic [5:0]       c_addr [5] = '{6'h00, 6'h08, 6'h3F, 6'h0F, 6'h0E};
	logic [7:0]       c_data [5] = '{8'hFF, 8'hC0, 8'h3F, 8'hA5, 8'h5A};

	mra_link_if mra_link_if_i ();

	mra_ctrl mra_ctrl_i (.ref_clk(ref_clk), .srst(srst), .link(mra_link_if_i.ctrl), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data), .mrr_ready(mrr_ready),
		.mrw_ready(mrw_ready), .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .pwr_down(pwr_down));

	mra_dram #(.RO_MASK(RO_MASK_TB)) mra_dram_i (.ref_clk(ref_clk), .srst(srst), .link(mra_link_if_i.dram),
		.peek_addr(peek_addr), .peek_data(peek_data), .bank_active(bank_active), .pwr_down(dram_pd),
		.mrw_seen(mrw_seen));

	mra_link_properties mra_link_properties_i (.ref_clk(ref_clk), .srst(srst), .cke(mra_link_if_i.cke),
		.cs(mra_link_if_i.cs), .ca(mra_link_if_i.ca), .dq(mra_link_if_i.dq), .dq_oe_n(mra_link_if_i.dq_oe_n));

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (mrw_seen === 1'b1)
			seen_cnt <= seen_cnt + 1;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic stop_test;
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
			errors++;
		end
	endtask

	function automatic int ck(input int ps);
		return (ps + TCK_PS - 1) / TCK_PS;
	endfunction

	function automatic int need_of(input mra_cmd_t f, input mra_cmd_t t);
		int ovl;
		ovl = (ck(TURN_MIN_PS) > TURN_MIN_CK) ? ck(TURN_MIN_PS) : TURN_MIN_CK;
		if (t == CMD_MRR)
			return (f == CMD_RD || f == CMD_RDA) ? DEF_BL / 2 : (f == CMD_PDX) ?
				ck(DEF_TXP_PS) + ck(DEF_ACTIVATE_TO_COLUMN_DELAY_PS) : DEF_WL + DEF_BL / 2 + 1 + ck(DEF_WRITE_TO_READ_TURNAROUND_PS);
		case (f)
			CMD_RD: return DEF_RL + DEF_BL / 2 + ck(DEF_STROBE_OUTPUT_DELAY_PS) + DEF_RPST_X2 / 2 + ovl;
			CMD_RDA: return DEF_RL + DEF_BL / 2 + ck(DEF_STROBE_OUTPUT_DELAY_PS) + DEF_RPST_X2 / 2 + ovl + DEF_READ_TO_PRECHARGE_CYCLES - 8;
			CMD_WRA, CMD_MWRA: return DEF_WL + 1 + DEF_BL / 2 + ovl + DEF_NWR;
			CMD_MRR: return DEF_RL + ck(DEF_STROBE_OUTPUT_DELAY_PS) + DEF_BL / 2 + 3;
			default: return DEF_WL + 1 + DEF_BL / 2 + ovl;
		endcase
	endfunction

	task automatic issue(input mra_cmd_t cmd, input logic [5:0] a, input logic [7:0] d, output int at);
		int   n;
		logic rdy;
		@(posedge ref_clk);
		#1;
		req_valid = 1'b1;
		req_cmd   = cmd;
		req_addr  = a;
		req_data  = d;
		rdy       = 1'b0;
		// Ready sampled settled, one step after the edge that set it
		for (n = 0; n < 200 && rdy !== 1'b1; n++)
		begin
			rdy = (cmd == CMD_MRR) ? mrr_ready : (cmd == CMD_MRW) ? mrw_ready : cmd_ready;
			at  = cyc;
			@(posedge ref_clk);
			#1;
		end
		req_valid = 1'b0;
		if (rdy !== 1'b1)
		begin
			errors++;
			stop_test();
		end
		if (cmd == CMD_MRW)
		begin
			mrw_cnt++;
			if (!RO_MASK_TB[a])
				exp_mr[a] = d;
		end
	endtask

	task automatic reg_read(input logic [5:0] a);
		int   t;
		int   n;
		logic got;
		issue(CMD_MRR, a, 8'h00, t);
		got = 1'b0;
		for (n = 0; n < 60 && !got; n++)
		begin
			@(posedge ref_clk);
			#1 got = (rd_valid === 1'b1);
		end
		if (!got)
		begin
			errors++;
			stop_test();
		end
		check("rd_data", exp_mr[a], rd_data);
		check("rd_latency", 1, (cyc - t) >= DEF_RL && (cyc - t) <= DEF_RL + 10);
		#1 peek_addr = a;
		repeat (2) @(posedge ref_clk);
		#1 check("peek_data", exp_mr[a], peek_data);
	endtask

	task automatic pair(input mra_cmd_t f, input mra_cmd_t t);
		int          t0;
		int          t1;
		logic [31:0] rv;
		rv = $random(seed);
		issue(f, rv[5:0], 8'h00, t0);
		issue(t, rv[13:8], rv[23:16], t1);
		check("gap", 1, (t1 - t0) >= need_of(f, t));
		repeat (40) @(posedge ref_clk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] rv;
		int          t;
		seed      = 32'h91bc;
		srst      = 1'b1;
		req_valid = 1'b0;
		req_cmd   = CMD_ACT;
		req_addr  = 6'h00;
		req_data  = 8'h00;
		peek_addr = 6'h00;
		cyc       = 0;
		errors    = 0;
		checked   = 0;
		mrw_cnt   = 0;
		seen_cnt  = 0;
		for (int i = 0; i < MR_COUNT; i++)
			exp_mr[i] = MR_RST_VAL;
		repeat (10) @(posedge ref_clk);
		#1 srst = 1'b0;
		check("reset_peek", MR_RST_VAL, peek_data);
		check("reset_bank", 0, bank_active);
		for (int i = 0; i < 5; i++)
		begin
			issue(CMD_MRW, c_addr[i], c_data[i], t);
			reg_read(c_addr[i]);
		end
		for (int i = 0; i < 12; i++)
		begin
			rv = $random(seed);
			issue(CMD_MRW, rv[5:0], rv[15:8], t);
			reg_read(rv[5:0]);
		end
		issue(CMD_ACT, 6'h00, 8'h00, t);
		issue(CMD_MRW, 6'h21, 8'h96, t);
		reg_read(6'h21);
		check("bank_kept", 1, bank_active);
		issue(CMD_PRE, 6'h00, 8'h00, t);
		reg_read(6'h21);
		check("bank_idle", 0, bank_active);
		for (int i = 0; i < 7; i++)
		begin
			pair(src[i], CMD_MRR);
			pair(src[i], CMD_MRW);
		end
		pair(CMD_MRR, CMD_MRW);
		issue(CMD_PDE, 6'h00, 8'h00, t);
		repeat (3) @(posedge ref_clk);
		#1 check("pwr_down", 1, pwr_down);
		check("dram_pd", 1, dram_pd);
		pair(CMD_PDX, CMD_MRR);
		check("pwr_up", 0, pwr_down);
		repeat (4) @(posedge ref_clk);
		check("mrw_seen", mrw_cnt, seen_cnt);
		stop_test();
	end
endmodule
`default_nettype wire
